// ===== hdl/ierb_bank.sv
// Purpose: Interrupt enable and request-flag register bank on AXI4-Lite.
// Assumes: Peripheral event inputs are one-cycle pulses on clk; pins async.
// Notes: Flags are sticky; software clears by writing 0, 1 leaves them.
// Notes: A set event in the same cycle as a clear wins over the clear.
// Notes: Timer and external enables sit outside, so those pendings are flags.
//
// Contract
// - Peripheral enable resets zero; bit7 gates direct-transfer.
// - Peripheral enable bit6 gates converter completion.
// - Peripheral enable bit4 gates serial one.
// - Reserved peripheral bits read zero, ignore writes.
// - Edge-line enable resets zero, bit per line.
// - Flags stay set on acceptance; software clears.
// - Writing 0 clears flag; writing 1 no change.
// - Timer B1 wrap sets timer flag bit7.
// - Timer A wrap sets timer flag bit6.
// - Configured external line edge sets flags 3..0.
// - Timer flags reset 0x10; bit4 one, bit5 zero.
// - Sleep with direct-transfer-on sets bit7 flag.
// - Conversion-active falling sets converter flag.
// - Serial one transfer done sets bit4 flag.
// - Peripheral flags reset to zero.
// - Edge-line transition sets its flag; reset zero.
// - Edge-line select: 0 falling, 1 rising.
// - External-line select: 0 falling, 1 rising.
// - Edge flags set even in port usage.
// - Disabled sources still set their flags.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ierb_bank
	import ierb_pkg::*;
(
	input wire logic clk, // System clock, 250 MHz.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic [ierb_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [ierb_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
	input wire logic [ierb_pkg::STRB_W-1:0] s_axi_wstrb, // Write strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [ierb_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [ierb_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic timerB1Wrap, // Timer B1 wrapped from max to zero.
	input wire logic timerAWrap, // Timer A wrapped from max to zero.
	input wire logic sleepExec, // Sleep instruction executes.
	input wire logic directXferOn, // Direct-transfer-on control level.
	input wire logic conversionActive, // Converter busy status level.
	input wire logic serialOneDone, // Serial channel one transfer done.
	input wire logic [3:0] extRequestLine, // External request pins, async.
	input wire logic [7:0] edgeRequestLine, // Edge request pins, async.
	output logic [3:0] extPending, // External line pending requests.
	output logic timerB1Pending, // Timer B1 request, flag only.
	output logic timerAPending, // Timer A request, flag only.
	output logic directXferPending, // Direct-transfer pending request.
	output logic converterDonePending, // Converter pending request.
	output logic serialOnePending, // Serial one pending request.
	output logic [7:0] edgePending // Edge-line pending requests.
);
	import ierb_pkg::*;

	// Registers of the bank.
	logic [7:0] periphEn_reg, edgeEn_reg, tmrFlags_reg;
	logic [7:0] periphFlags_reg, edgeFlags_reg, edgeSel_reg, extCfg_reg;
	logic [7:0] periphEn_next, edgeEn_next, tmrFlags_next;
	logic [7:0] periphFlags_next, edgeFlags_next, edgeSel_next, extCfg_next;
	logic convActDly_reg;
	logic [3:0] extSync1_reg, extSync2_reg, extPrev_reg;
	logic [7:0] edgeSync1_reg, edgeSync2_reg, edgePrev_reg;

	// Write channel state: address and data may arrive in either order.
	logic awHeld_reg, wHeld_reg;
	logic [ADDR_W-1:0] awAddr_reg;
	logic [DATA_W-1:0] wData_reg;
	logic [STRB_W-1:0] wStrb_reg;
	logic bValid_reg, rValid_reg;
	logic [1:0] bResp_reg, rResp_reg;
	logic [DATA_W-1:0] rData_reg;

	// Decode of a word address to a register select.
	function automatic logic [7:0] regSelect(input logic [ADDR_W-1:0] a);
		logic [7:0] s;
		s = 8'h00;
		if (a == OFF_PERIPH_EN) s = 8'h01;
		else if (a == OFF_EDGE_EN) s = 8'h02;
		else if (a == OFF_TMR_FLAGS) s = 8'h04;
		else if (a == OFF_PERIPH_FLAGS) s = 8'h08;
		else if (a == OFF_EDGE_FLAGS) s = 8'h10;
		else if (a == OFF_EDGE_SEL) s = 8'h20;
		else if (a == OFF_EXT_CFG) s = 8'h40;
		return s;
	endfunction

	// Bus handshake wires. One write in flight; bvalid blocks new writes.
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire awHave = awHeld_reg || awTake;
	wire wHave = wHeld_reg || wTake;
	wire [ADDR_W-1:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
	wire [DATA_W-1:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
	wire [STRB_W-1:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
	wire wrFire = awHave && wHave && !bValid_reg;
	wire [7:0] wrSel = regSelect(wrAddr);
	wire wrLow = wrFire && wrStrb[0];
	wire [7:0] wrByte = wrData[7:0];
	wire arTake = s_axi_arvalid && s_axi_arready;
	wire [7:0] rdSel = regSelect(s_axi_araddr);

	// Ready drops while a half is held or a response waits for bready (rready for the read side).
	assign s_axi_awready = !awHeld_reg && !bValid_reg;
	assign s_axi_wready = !wHeld_reg && !bValid_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rresp = rResp_reg;
	assign s_axi_rdata = rData_reg;

	// Edge detection on synchronised pins; select 1 rising, 0 falling.
	wire [7:0] edgeRise = edgeSync2_reg & ~edgePrev_reg;
	wire [7:0] edgeFall = ~edgeSync2_reg & edgePrev_reg;
	wire [7:0] edgeHit = (edgeSel_reg & edgeRise) | (~edgeSel_reg & edgeFall);

	// External lines count only while configured as request inputs.
	wire [3:0] extRise = extSync2_reg & ~extPrev_reg;
	wire [3:0] extFall = ~extSync2_reg & extPrev_reg;
	wire [3:0] extSel = extCfg_reg[3:0];
	wire [3:0] extUse = extCfg_reg[7:4];
	wire [3:0] extHit = extUse & ((extSel & extRise) | (~extSel & extFall));

	// Peripheral events, recognised regardless of enables.
	wire convDone = convActDly_reg && !conversionActive;
	wire dxEvent = sleepExec && directXferOn;
	wire [7:0] tmrSet = {timerB1Wrap, timerAWrap, 2'b00, extHit};
	wire [7:0] periphSet = {dxEvent, convDone, 1'b0, serialOneDone, 4'h0};

	// A write of 0 clears, 1 keeps; a set in the same cycle wins.
	wire [7:0] clrMask = wrByte;
	assign tmrFlags_next = (wrLow && wrSel[2])
		? (((tmrFlags_reg & clrMask) | tmrSet) & TMR_FLAG_MASK) | TMR_FIXED_ONE
		: ((tmrFlags_reg | tmrSet) & TMR_FLAG_MASK) | TMR_FIXED_ONE;
	assign periphFlags_next = (wrLow && wrSel[3])
		? ((periphFlags_reg & clrMask) | periphSet) & PERIPH_MASK
		: (periphFlags_reg | periphSet) & PERIPH_MASK;
	assign edgeFlags_next = (wrLow && wrSel[4])
		? (edgeFlags_reg & clrMask) | edgeHit
		: edgeFlags_reg | edgeHit;

	// Enable and select writes; reserved enable bits never store a 1.
	assign periphEn_next = (wrLow && wrSel[0])
		? wrByte & PERIPH_MASK : periphEn_reg;
	assign edgeEn_next = (wrLow && wrSel[1]) ? wrByte : edgeEn_reg;
	assign edgeSel_next = (wrLow && wrSel[5]) ? wrByte : edgeSel_reg;
	assign extCfg_next = (wrLow && wrSel[6])
		? wrByte & EXT_CFG_MASK : extCfg_reg;

	// Read data mux, low byte only; upper bits zero.
	wire [7:0] rdByte = rdSel[0] ? periphEn_reg
		: rdSel[1] ? edgeEn_reg
		: rdSel[2] ? tmrFlags_reg
		: rdSel[3] ? periphFlags_reg
		: rdSel[4] ? edgeFlags_reg
		: rdSel[5] ? edgeSel_reg
		: rdSel[6] ? extCfg_reg : 8'h00;

	// Register state update.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			periphEn_reg <= RST_PERIPH_EN;
			edgeEn_reg <= RST_EDGE_EN;
			tmrFlags_reg <= RST_TMR_FLAGS;
			periphFlags_reg <= RST_PERIPH_FLAGS;
			edgeFlags_reg <= RST_EDGE_FLAGS;
			edgeSel_reg <= RST_EDGE_SEL;
			extCfg_reg <= RST_EXT_CFG;
		end else begin
			periphEn_reg <= periphEn_next;
			edgeEn_reg <= edgeEn_next;
			tmrFlags_reg <= tmrFlags_next;
			periphFlags_reg <= periphFlags_next;
			edgeFlags_reg <= edgeFlags_next;
			edgeSel_reg <= edgeSel_next;
			extCfg_reg <= extCfg_next;
		end
	end

	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			extSync1_reg <= 4'hF;
			extSync2_reg <= 4'hF;
			extPrev_reg <= 4'hF;
			edgeSync1_reg <= 8'hFF;
			edgeSync2_reg <= 8'hFF;
			edgePrev_reg <= 8'hFF;
			convActDly_reg <= 1'b0;
		end else begin
			extSync1_reg <= extRequestLine;
			extSync2_reg <= extSync1_reg;
			extPrev_reg <= extSync2_reg;
			edgeSync1_reg <= edgeRequestLine;
			edgeSync2_reg <= edgeSync1_reg;
			edgePrev_reg <= edgeSync2_reg;
			convActDly_reg <= conversionActive;
		end
	end

	// Write channel: hold whichever half arrives first.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			wStrb_reg <= '0;
			bValid_reg <= 1'b0;
			bResp_reg <= RESP_OKAY;
		end else begin
			if (wrFire) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				bValid_reg <= 1'b1;
				bResp_reg <= (wrSel == 8'h00) ? RESP_SLVERR : RESP_OKAY;
			end else begin
				if (awTake) begin
					awHeld_reg <= 1'b1;
					awAddr_reg <= s_axi_awaddr;
				end
				if (wTake) begin
					wHeld_reg <= 1'b1;
					wData_reg <= s_axi_wdata;
					wStrb_reg <= s_axi_wstrb;
				end
				if (bValid_reg && s_axi_bready) begin
					bValid_reg <= 1'b0;
				end
			end
		end
	end

	// Read channel: answer one cycle after the address is taken.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rValid_reg <= 1'b0;
			rData_reg <= '0;
			rResp_reg <= RESP_OKAY;
		end else if (arTake) begin
			rValid_reg <= 1'b1;
			rData_reg <= {24'h000000, rdByte};
			rResp_reg <= (rdSel == 8'h00) ? RESP_SLVERR : RESP_OKAY;
		end else if (rValid_reg && s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end

	// Pending requests to the core: flag AND enable, every clock.
	assign directXferPending = periphFlags_reg[BIT_DIRECT_XFER]
		& periphEn_reg[BIT_DIRECT_XFER];
	assign converterDonePending = periphFlags_reg[BIT_CONVERTER]
		& periphEn_reg[BIT_CONVERTER];
	assign serialOnePending = periphFlags_reg[BIT_SERIAL_ONE]
		& periphEn_reg[BIT_SERIAL_ONE];
	assign edgePending = edgeFlags_reg & edgeEn_reg;
	// Timer and external enables live in a register outside this bank.
	assign timerB1Pending = tmrFlags_reg[BIT_TIMER_B1];
	assign timerAPending = tmrFlags_reg[BIT_TIMER_A];
	assign extPending = tmrFlags_reg[3:0];

	// Checks.
	flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
		(tmrFlags_reg[BIT_TIMER_A] && !(s_axi_wvalid || wHeld_reg))
		|=> tmrFlags_reg[BIT_TIMER_A])
		else $error("timer A flag dropped without write");
	tmr_fixed_a: assert property (@(posedge clk) disable iff (!rst_b)
		tmrFlags_reg[5:4] == 2'b01)
		else $error("timer flag fixed bits wrong");
	periph_rsv_a: assert property (@(posedge clk) disable iff (!rst_b)
		((periphEn_reg | periphFlags_reg) & ~PERIPH_MASK) == 8'h00)
		else $error("reserved peripheral bits set");
	b1_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		timerB1Wrap |=> tmrFlags_reg[BIT_TIMER_B1])
		else $error("timer B1 wrap lost");
	dx_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(sleepExec && directXferOn) |=> periphFlags_reg[BIT_DIRECT_XFER])
		else $error("direct transfer event lost");
	conv_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(conversionActive)) |=> periphFlags_reg[BIT_CONVERTER])
		else $error("conversion done lost");
	serial_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		serialOneDone |=> periphFlags_reg[BIT_SERIAL_ONE])
		else $error("serial done lost");
	edge_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
		(edgeSel_reg[0] && $rose(edgeSync2_reg[0]))
		|=> edgeFlags_reg[0])
		else $error("edge line 0 rising lost");
	pend_and_a: assert property (@(posedge clk) disable iff (!rst_b)
		edgePending == (edgeFlags_reg & edgeEn_reg))
		else $error("edge pending mismatch");
	// Timer A wrap must land in its flag on the next clock.
	ta_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		timerAWrap |=> tmrFlags_reg[BIT_TIMER_A])
		else $error("timer A wrap lost");
	// Falling edge on a line selected for falling sense.
	edge_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!edgeSel_reg[1] && $fell(edgeSync2_reg[1]))
		|=> edgeFlags_reg[1])
		else $error("edge line 1 falling lost");
	// A disabled edge line still records its edge.
	edge_masked_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!edgeEn_reg[6] && !edgeSel_reg[6] && $fell(edgeSync2_reg[6]))
		|=> edgeFlags_reg[6])
		else $error("disabled edge line 6 lost its flag");
	// Configured external lines follow their own select bit.
	ext_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
		(extUse[0] && !extSel[0] && $fell(extSync2_reg[0]))
		|=> tmrFlags_reg[0])
		else $error("external line 0 falling lost");
	ext_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
		(extUse[3] && extSel[3] && $rose(extSync2_reg[3]))
		|=> tmrFlags_reg[3])
		else $error("external line 3 rising lost");
	// An unconfigured line never raises its flag, whatever the pin does.
	ext_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!extUse[3] && !tmrFlags_reg[3]) |=> !tmrFlags_reg[3])
		else $error("unconfigured line 3 set its flag");
	// Sleep without the direct-transfer-on level must not raise the flag.
	dx_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		(sleepExec && !directXferOn && !periphFlags_reg[BIT_DIRECT_XFER])
		|=> !periphFlags_reg[BIT_DIRECT_XFER])
		else $error("direct transfer flag set without its level");
	// Writing 0 clears unless an event collides; writing 1 keeps.
	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wrLow && wrSel[3] && !wrByte[BIT_SERIAL_ONE] && !serialOneDone)
		|=> !periphFlags_reg[BIT_SERIAL_ONE])
		else $error("serial flag not cleared by write of 0");
	flag_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wrLow && wrSel[2] && wrByte[BIT_TIMER_A]
			&& tmrFlags_reg[BIT_TIMER_A])
		|=> tmrFlags_reg[BIT_TIMER_A])
		else $error("timer A flag lost on write of 1");
	// A timer B1 flag survives any cycle with no write to its register.
	b1_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
		(tmrFlags_reg[BIT_TIMER_B1] && !(wrLow && wrSel[2]))
		|=> tmrFlags_reg[BIT_TIMER_B1])
		else $error("timer B1 flag dropped without write");
	// Edge flags are sticky against anything but a write to them.
	edge_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
		(edgeFlags_reg[0] && !(wrLow && wrSel[4])) |=> edgeFlags_reg[0])
		else $error("edge line 0 flag dropped without write");
	// Converter completion is recorded with its enable off as well.
	conv_masked_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!periphEn_reg[BIT_CONVERTER] && convDone)
		|=> periphFlags_reg[BIT_CONVERTER])
		else $error("disabled converter lost its flag");
	// Enable writes land as written, reserved bits masked.
	edge_en_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wrLow && wrSel[1]) |=> edgeEn_reg == $past(wrByte))
		else $error("edge enable write lost");
	periph_en_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wrLow && wrSel[0])
		|=> periphEn_reg == ($past(wrByte) & PERIPH_MASK))
		else $error("peripheral enable write wrong");
	// Reset values; no disable here since reset is the antecedent.
	reset_vals_a: assert property (@(posedge clk)
		!rst_b |=> (periphEn_reg == RST_PERIPH_EN)
		&& (edgeEn_reg == RST_EDGE_EN) && (tmrFlags_reg == RST_TMR_FLAGS)
		&& (periphFlags_reg == RST_PERIPH_FLAGS)
		&& (edgeFlags_reg == RST_EDGE_FLAGS))
		else $error("register bank reset values wrong");
endmodule
`default_nettype wire

// ===== pkg/ierb_pkg.sv
// Purpose: Constants for the interrupt enable and request-flag bank.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Offsets are byte addresses of aligned words.
`default_nettype none
package ierb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	// Register byte offsets.
	localparam logic [7:0] OFF_PERIPH_EN = 8'h00;
	localparam logic [7:0] OFF_EDGE_EN = 8'h04;
	localparam logic [7:0] OFF_TMR_FLAGS = 8'h08;
	localparam logic [7:0] OFF_PERIPH_FLAGS = 8'h0C;
	localparam logic [7:0] OFF_EDGE_FLAGS = 8'h10;
	localparam logic [7:0] OFF_EDGE_SEL = 8'h14;
	localparam logic [7:0] OFF_EXT_CFG = 8'h18;
	// Reset values.
	localparam logic [7:0] RST_PERIPH_EN = 8'h00;
	localparam logic [7:0] RST_EDGE_EN = 8'h00;
	localparam logic [7:0] RST_TMR_FLAGS = 8'h10;
	localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
	localparam logic [7:0] RST_EDGE_FLAGS = 8'h00;
	localparam logic [7:0] RST_EDGE_SEL = 8'h00;
	localparam logic [7:0] RST_EXT_CFG = 8'h00;
	// Writable-bit masks and forced-one masks.
	localparam logic [7:0] PERIPH_MASK = 8'hD0;
	localparam logic [7:0] TMR_FLAG_MASK = 8'hCF;
	localparam logic [7:0] TMR_FIXED_ONE = 8'h10;
	localparam logic [7:0] EXT_CFG_MASK = 8'hFF;
	// Field positions.
	localparam int BIT_DIRECT_XFER = 7;
	localparam int BIT_CONVERTER = 6;
	localparam int BIT_SERIAL_ONE = 4;
	localparam int BIT_TIMER_B1 = 7;
	localparam int BIT_TIMER_A = 6;
	localparam int EXT_LINES = 4;
	localparam int EDGE_LINES = 8;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== tb/ierb_cpu_model.sv
// Purpose: CPU core model that reaches the bank over AXI4-Lite.
// Assumes: Each task is entered just after a rising clock edge.
// Notes: Every wait is bounded; running out raises hung.
`timescale 1ns/1ps
`default_nettype none
module ierb_cpu_model (
	input wire logic clk, // System clock.
	output logic [7:0] awaddr, // Write address.
	output logic awvalid, // Write address valid.
	input wire logic awready, // Write address ready.
	output logic [31:0] wdata, // Write data.
	output logic [3:0] wstrb, // Write strobes.
	output logic wvalid, // Write data valid.
	input wire logic wready, // Write data ready.
	input wire logic [1:0] bresp, // Write response.
	input wire logic bvalid, // Write response valid.
	output logic bready, // Write response ready.
	output logic [7:0] araddr, // Read address.
	output logic arvalid, // Read address valid.
	input wire logic arready, // Read address ready.
	input wire logic [31:0] rdata, // Read data.
	input wire logic [1:0] rresp, // Read response.
	input wire logic rvalid, // Read data valid.
	output logic rready, // Read data ready.
	output logic hung // A bus wait ran out.
);
	// Idle bus at time zero so the bank sees no request during reset.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, hung} = '0;
	end
	// Handshakes are judged mid-cycle, where the edge's values are settled.
	// Each call lets one edge pass first, so a release and the next
	// raise never share a time step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				return;
			end
		end
		hung = 1'b1;
	endtask
	// Read: hold the address until taken, rready until rvalid.
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ah, rh;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ah) arvalid <= 1'b0;
			if (rh) begin
				rready <= 1'b0;
				return;
			end
		end
		hung = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== tb/ierb_bank_tb.sv
// Purpose: Self-checking bench for the request bank.
// Assumes: Pins idle high; events are one-cycle pulses.
// Notes: Pin edges are given five cycles to pass the sync flops.
`timescale 1ns/1ps
`default_nettype none
module ierb_bank_tb;
	import ierb_pkg::*;
	logic clk, rst_b, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, hung;
	logic [7:0] awa, ara, edg, edgP;
	logic [31:0] wd, rdat;
	logic [3:0] ws, ext, extP;
	logic [1:0] bresp, rresp;
	logic tb1, ta, slp, dxOn, cAct, s1, tb1P, taP, dxP, cdP, s1P;
	int mismatches = 0;
	int n_checks = 0;
	ierb_bank DUT (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .timerB1Wrap(tb1), .timerAWrap(ta),
		.sleepExec(slp), .directXferOn(dxOn), .conversionActive(cAct),
		.serialOneDone(s1), .extRequestLine(ext), .edgeRequestLine(edg),
		.extPending(extP), .timerB1Pending(tb1P), .timerAPending(taP),
		.directXferPending(dxP), .converterDonePending(cdP),
		.serialOnePending(s1P), .edgePending(edgP));
	ierb_cpu_model cpu (.clk(clk), .awaddr(awa), .awvalid(awv),
		.awready(awr), .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wr_),
		.bresp(bresp), .bvalid(bv), .bready(br), .araddr(ara),
		.arvalid(arv), .arready(arr), .rdata(rdat), .rresp(rresp),
		.rvalid(rv), .rready(rr), .hung(hung));
	// Free-running 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
		if (hung) begin
			mismatches++;
			report_and_stop();
		end
	endtask
	// Register access with its response judged as well.
	task automatic rdc(logic [7:0] a, logic [31:0] e, logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		cpu.rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic wrc(logic [7:0] a, logic [7:0] d, logic [1:0] er);
		logic [1:0] r;
		cpu.wr(a, {24'h0, d}, 4'hF, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	// Reset values, then an unmapped place on both channels.
	task automatic t_reset();
		logic [1:0] r;
		rdc(OFF_PERIPH_EN, 32'h0, RESP_OKAY);
		rdc(OFF_EDGE_EN, 32'h0, RESP_OKAY);
		rdc(OFF_TMR_FLAGS, 32'h10, RESP_OKAY);
		rdc(OFF_PERIPH_FLAGS, 32'h0, RESP_OKAY);
		rdc(OFF_EDGE_FLAGS, 32'h0, RESP_OKAY);
		wrc(8'h1C, 8'hFF, RESP_SLVERR);
		rdc(8'h1C, 32'h0, RESP_SLVERR);
		wrc(OFF_PERIPH_EN, 8'hFF, RESP_OKAY);
		rdc(OFF_PERIPH_EN, 32'hD0, RESP_OKAY);
		wrc(OFF_EDGE_EN, 8'hA5, RESP_OKAY);
		rdc(OFF_EDGE_EN, 32'hA5, RESP_OKAY);
		// Low byte strobe off: answered OKAY, register untouched.
		cpu.wr(OFF_EDGE_EN, 32'h0000005A, 4'hE, r);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
		rdc(OFF_EDGE_EN, 32'hA5, RESP_OKAY);
		wrc(OFF_PERIPH_EN, 8'h00, RESP_OKAY);
	endtask
	// Events with enables off: flags set, gated pendings stay low.
	task automatic t_events();
		slp <= 1'b1;
		cyc(1);
		slp <= 1'b0;
		rdc(OFF_PERIPH_FLAGS, 32'h0, RESP_OKAY);
		{tb1, ta, slp, s1, cAct, dxOn} <= 6'h3F;
		cyc(1);
		{tb1, ta, slp, s1, cAct} <= 5'h0;
		rdc(OFF_TMR_FLAGS, 32'hD0, RESP_OKAY);
		rdc(OFF_PERIPH_FLAGS, 32'hD0, RESP_OKAY);
		chk("pend", 32'h18, {27'h0, tb1P, taP, dxP, cdP, s1P});
		wrc(OFF_PERIPH_EN, 8'hD0, RESP_OKAY);
		chk("pend", 32'h1F, {27'h0, tb1P, taP, dxP, cdP, s1P});
		wrc(OFF_TMR_FLAGS, 8'hFF, RESP_OKAY);
		wrc(OFF_PERIPH_FLAGS, 8'hFF, RESP_OKAY);
		rdc(OFF_TMR_FLAGS, 32'hD0, RESP_OKAY);
		rdc(OFF_PERIPH_FLAGS, 32'hD0, RESP_OKAY);
		wrc(OFF_TMR_FLAGS, 8'h00, RESP_OKAY);
		wrc(OFF_PERIPH_FLAGS, 8'h00, RESP_OKAY);
		rdc(OFF_TMR_FLAGS, 32'h10, RESP_OKAY);
		chk("pend", 32'h0, {27'h0, tb1P, taP, dxP, cdP, s1P});
	endtask
	// Pin edges in both senses on edge and external lines.
	task automatic t_pins();
		wrc(OFF_EDGE_EN, 8'h0F, RESP_OKAY);
		edg <= 8'h00;
		cyc(5);
		rdc(OFF_EDGE_FLAGS, 32'hFF, RESP_OKAY);
		chk("edgP", 32'h0F, {24'h0, edgP});
		wrc(OFF_EDGE_FLAGS, 8'h00, RESP_OKAY);
		wrc(OFF_EDGE_SEL, 8'hFF, RESP_OKAY);
		edg <= 8'hFF;
		cyc(5);
		rdc(OFF_EDGE_FLAGS, 32'hFF, RESP_OKAY);
		wrc(OFF_EXT_CFG, 8'h30, RESP_OKAY);
		ext <= 4'h0;
		cyc(5);
		rdc(OFF_TMR_FLAGS, 32'h13, RESP_OKAY);
		chk("extP", 32'h3, {28'h0, extP});
		wrc(OFF_TMR_FLAGS, 8'h00, RESP_OKAY);
		wrc(OFF_EXT_CFG, 8'hFF, RESP_OKAY);
		ext <= 4'hF;
		cyc(5);
		rdc(OFF_TMR_FLAGS, 32'h1F, RESP_OKAY);
	endtask
	// Main sequence: reset for four cycles, then each scenario.
	initial begin
		rst_b = 1'b0;
		{tb1, ta, slp, dxOn, cAct, s1} = 6'h0;
		ext = 4'hF;
		edg = 8'hFF;
		cyc(4);
		rst_b <= 1'b1;
		cyc(4);
		t_reset();
		t_events();
		t_pins();
		report_and_stop();
	end
endmodule
`default_nettype wire
